/* File: hdl/scpc_chain.sv */
`timescale 1ns/100ps
module scpc_chain
    import scpc_pkg::*;
#(
    parameter int N_CHAN = MAX_CHANNELS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N_CHAN-1:0] cmd_need_i,
    input wire logic [N_CHAN-1:0] data_need_i,
    input wire logic [N_CHAN-1:0] keep_priority_i,
    output logic [N_CHAN-1:0] command_word_cycle_o,
    output logic [N_CHAN-1:0] data_word_cycle_o,
    output logic [N_CHAN-1:0] busy_o,
    scpc_if.channel bus
);
    // Every per-channel record sits in one packed state, so the whole chain
    // advances in a single registered step.
    typedef struct packed {
        logic [N_CHAN-1:0] pend_cmd;
        logic [N_CHAN-1:0] pend_data;
        logic [N_CHAN-1:0] demand;
        logic [N_CHAN-1:0] extra_cmd;
        logic [N_CHAN-1:0] command_cycle_flag;
        logic [N_CHAN-1:0] data_cycle_flag;
        logic [N_CHAN-1:0] won;
    } scpc_chan_s;

    scpc_chan_s st_reg;
    scpc_chan_s st_next;

    // Cycle time decodes, common to every position.
    logic at_demand;
    logic at_grant;
    logic at_capture;
    logic at_last;

    // Chain lines as seen by each position.
    logic [N_CHAN-1:0] hold_out;
    logic [N_CHAN-1:0] hold_in;

    // Per-position decisions for this clock.
    logic [N_CHAN-1:0] wants;
    logic [N_CHAN-1:0] raise;
    logic [N_CHAN-1:0] accept;
    logic [N_CHAN-1:0] take_data;
    logic [N_CHAN-1:0] take_cmd;

    // What each position still owes after this clock.
    logic [N_CHAN-1:0] cmd_left;
    logic [N_CHAN-1:0] data_left;
    logic [N_CHAN-1:0] extra_left;
    logic [N_CHAN-1:0] owed;
    logic [N_CHAN-1:0] release_now;

    assign at_demand = (bus.cycle_time == TIME_DEMAND);
    assign at_grant = (bus.cycle_time == TIME_GRANT);
    assign at_capture = (bus.cycle_time == TIME_CAPTURE);
    assign at_last = (bus.cycle_time == TIME_LAST);

    genvar g;
    generate
        for (g = 0; g < N_CHAN; g++) begin : g_chan
            // Anything latched, the promised extra command cycle included, keeps the channel asking.
            assign wants[g] = st_reg.pend_cmd[g] | st_reg.pend_data[g] | st_reg.extra_cmd[g];

            // The top position has nobody above it, so it never sees a hold.
            if (g == N_CHAN - 1) begin : g_top
                assign hold_in[g] = 1'b0;
            end else begin : g_lower
                assign hold_in[g] = |hold_out[N_CHAN-1:g+1];
            end

            // The bottom position has nobody below it to hold off.
            if (g == 0) begin : g_bottom
                assign hold_out[g] = 1'b0;
            end else begin : g_upper
                assign hold_out[g] = st_reg.demand[g];
            end

            // A new demand goes out only at time 3; one already standing is kept.
            assign raise[g] = at_demand & ~st_reg.demand[g] & wants[g];

            // Only the highest demanding position can take a grant, so no two
            // channels ever own the same storage cycle.
            assign accept[g] = st_reg.demand[g] & ~hold_in[g] & bus.grant;

            // Data takes precedence over command since it is paced by the device.
            assign take_data[g] = at_capture & st_reg.won[g] & st_reg.pend_data[g];
            assign take_cmd[g] = at_capture & st_reg.won[g] & ~st_reg.pend_data[g];

            // A need that arrives in the very cycle of its capture is kept, so a
            // short pulse from the channel is never lost.
            assign data_left[g] = take_data[g] ? data_need_i[g] : (st_reg.pend_data[g] | data_need_i[g]);
            assign cmd_left[g] = take_cmd[g] ? cmd_need_i[g] : (st_reg.pend_cmd[g] | cmd_need_i[g]);
            assign extra_left[g] = take_cmd[g] ? (keep_priority_i[g] & ~st_reg.extra_cmd[g]) :
                st_reg.extra_cmd[g];
            assign owed[g] = cmd_left[g] | data_left[g] | extra_left[g];

            // The demand, and with it the hold on lower channels, stays up while anything is owed.
            assign release_now[g] = at_capture & st_reg.won[g] & ~owed[g];
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.pend_cmd = cmd_left;
        st_next.pend_data = data_left;
        st_next.extra_cmd = extra_left;
        // The win lives only through the capture time that follows the grant.
        st_next.won = at_grant ? accept : '0;
        st_next.demand = (st_reg.demand | raise) & ~release_now;
        st_next.command_cycle_flag = st_reg.command_cycle_flag | take_cmd;
        st_next.data_cycle_flag = st_reg.data_cycle_flag | take_data;
        // Each flag marks exactly the next storage cycle, so it ends with the period.
        if (at_last) begin
            st_next.command_cycle_flag = '0;
            st_next.data_cycle_flag = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.demand = st_reg.demand;
    assign bus.hold_out = hold_out;
    assign bus.capture = st_reg.won;
    assign command_word_cycle_o = st_reg.command_cycle_flag;
    assign data_word_cycle_o = st_reg.data_cycle_flag;
    assign busy_o = st_reg.demand;
endmodule // scpc_chain

/* File: hdl/scpc_pkg.sv */
package scpc_pkg;
    // Cycle time pulses are numbered within one storage cycle period.
    localparam int CYCLE_TIMES = 12;
    localparam logic [3:0] TIME_DEMAND = 4'h3;
    localparam logic [3:0] TIME_GRANT = 4'h9;
    localparam logic [3:0] TIME_CAPTURE = 4'hA;
    localparam logic [3:0] TIME_LAST = 4'hB;
    localparam int MAX_CHANNELS = 8;
    localparam int CHAN_ID_W = 3;

    typedef enum logic [1:0] {
        SCPC_IDLE,
        SCPC_DEMAND,
        SCPC_CYCLE
    } scpc_state_e;
endpackage

/* File: hdl/scpc_if.sv */
`timescale 1ns/100ps
// Shared storage-cycle lines between the computer and a chain of channels.
// The chain is carried as vectors indexed by position; position 0 is the
// least remote, the highest index is the most remote and is served first.
interface scpc_if #(
    parameter int N_CHAN = 8
);
    logic [3:0] cycle_time;
    logic [N_CHAN-1:0] demand;
    logic [N_CHAN-1:0] hold_out;
    logic grant;
    logic [N_CHAN-1:0] capture;

    modport channel (
        input cycle_time,
        input grant,
        output hold_out,
        output demand,
        output capture
    );
    modport computer (
        output cycle_time,
        output grant,
        input demand,
        input hold_out,
        input capture
    );
endinterface // scpc_if

/* File: hdl/scpc_computer.sv */
`timescale 1ns/100ps
module scpc_computer
    import scpc_pkg::*;
#(
    parameter int N_CHAN = MAX_CHANNELS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cpu_want_i,
    output logic cpu_cycle_o,
    output logic [3:0] cycle_time_o,
    scpc_if.computer bus
);
    typedef struct packed {
        logic [3:0] tick;
        logic grant;
        logic granted;
        logic cpu_cycle;
    } scpc_cpu_s;

    scpc_cpu_s st_reg;
    scpc_cpu_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.grant = 1'b0;
        st_next.tick = (st_reg.tick == TIME_LAST) ? 4'h0 : st_reg.tick + 4'h1;
        if (st_reg.tick == TIME_LAST) begin
            st_next.cpu_cycle = 1'b0;
            st_next.granted = 1'b0;
        end
        // A grant at time 9 serves any demand, single channel or chain.
        if (st_next.tick == TIME_GRANT && |bus.demand) begin
            st_next.grant = 1'b1;
            st_next.granted = 1'b1;
        end
        // The computer only uses storage when no channel is demanding. A granted
        // period hands the next cycle to a channel even if its demand just dropped.
        if (st_reg.tick == TIME_LAST && cpu_want_i && !(|bus.demand) && !st_reg.granted) begin
            st_next.cpu_cycle = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.cycle_time = st_reg.tick;
    assign bus.grant = st_reg.grant;
    assign cycle_time_o = st_reg.tick;
    assign cpu_cycle_o = st_reg.cpu_cycle;
endmodule // scpc_computer

/* File: testbench/scpc_chain_assertions.sv */
`timescale 1ns/100ps
module scpc_chain_assertions
    import scpc_pkg::*;
#(
    parameter int N_CHAN = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] cycle_time,
    input wire logic [N_CHAN-1:0] demand,
    input wire logic [N_CHAN-1:0] hold_out,
    input wire logic grant,
    input wire logic [N_CHAN-1:0] capture
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    one_user_a: assert property ($onehot0(capture)) else $error("two captures at once");
    grant_time_a: assert property (grant |-> cycle_time == TIME_GRANT) else $error("grant off time");
    grant_pulse_a: assert property (grant |=> !grant) else $error("grant too long");
    grant_cause_a: assert property (grant |-> |demand) else $error("grant without demand");
    capture_time_a: assert property (|capture |-> cycle_time == TIME_CAPTURE) else $error("capture off time");
    capture_cause_a: assert property (|capture |-> $past(grant)) else $error("capture without grant");
    top_served_a: assert property (|capture |-> ($past(demand) & ~(capture - 1'b1)) == capture)
        else $error("lower channel served first");
    demand_rise_a: assert property (|(demand & ~$past(demand)) |-> $past(cycle_time) == TIME_DEMAND)
        else $error("demand raised off time");
    demand_hold_a: assert property (($past(demand) & ~demand & ~(capture | $past(capture))) == '0)
        else $error("demand dropped unserved");
    hold_chain_a: assert property ((hold_out >> 1) == (demand >> 1) && !hold_out[0])
        else $error("hold line does not follow demand");
    held_idle_a: assert property (|capture |-> ($past(hold_out) & ~((capture << 1) - 1'b1)) == '0)
        else $error("held channel captured");
    cover property (capture[N_CHAN-1]);
    cover property (|capture ##12 |capture);
    cover property (grant);
endmodule // scpc_chain_assertions

/* File: testbench/scpc_chain_test.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module scpc_chain_test
    import scpc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cpu_want_i = 1'b1;
    logic [7:0] cmd_need_i = 8'h00;
    logic [7:0] data_need_i = 8'h00;
    logic [7:0] keep_priority_i = 8'h00;
    logic [7:0] command_word_cycle_o, data_word_cycle_o, busy_o;
    logic cpu_cycle_o;
    logic [3:0] cycle_time_o;
    logic [3:0] log_q[$];
    int mismatches = 0;
    int checks_done = 0;
    // The first period after reset and every period won by a channel are not free for the computer.
    logic skip_cpu = 1'b1;
    logic cpu_free;
    always #5 clk_i = ~clk_i;
    scpc_if #(.N_CHAN(8)) u_scpc_if ();
    scpc_chain #(.N_CHAN(8)) u_scpc_chain (.clk_i(clk_i), .rst_i(rst_i), .cmd_need_i(cmd_need_i),
        .data_need_i(data_need_i), .keep_priority_i(keep_priority_i), .command_word_cycle_o(command_word_cycle_o),
        .data_word_cycle_o(data_word_cycle_o), .busy_o(busy_o), .bus(u_scpc_if));
    scpc_computer #(.N_CHAN(8)) u_scpc_computer (.clk_i(clk_i), .rst_i(rst_i), .cpu_want_i(cpu_want_i),
        .cpu_cycle_o(cpu_cycle_o), .cycle_time_o(cycle_time_o), .bus(u_scpc_if));
    scpc_chain_assertions #(.N_CHAN(8)) u_scpc_chain_assertions (.clk_i(clk_i), .rst_i(rst_i),
        .cycle_time(u_scpc_if.cycle_time), .demand(u_scpc_if.demand), .hold_out(u_scpc_if.hold_out),
        .grant(u_scpc_if.grant), .capture(u_scpc_if.capture));
    // Each flag is logged as kind and channel, so the order of service can be compared as a whole.
    always @(posedge clk_i) begin
        for (int i = 0; i < 8; i++) begin
            if (command_word_cycle_o[i] === 1'b1) log_q.push_back({1'b0, 3'(i)});
            if (data_word_cycle_o[i] === 1'b1) log_q.push_back({1'b1, 3'(i)});
        end
        if (!rst_i && (command_word_cycle_o | data_word_cycle_o) != 8'h00) `CHK("flag time", TIME_LAST, cycle_time_o)
        cpu_free = !skip_cpu && u_scpc_if.demand == 8'h00;
        if (!rst_i && cycle_time_o == 4'h0) `CHK("cpu cycle", cpu_free, cpu_cycle_o)
        if (!rst_i && cycle_time_o == TIME_LAST) skip_cpu = (command_word_cycle_o | data_word_cycle_o) != 8'h00;
    end
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic need(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        cmd_need_i = c;
        data_need_i = d;
        @(posedge clk_i);
        #1;
        cmd_need_i = 8'h00;
        data_need_i = 8'h00;
    endtask
    task automatic expect_log(input string nm, input logic [3:0] e[$]);
        for (int k = 0; k < 300 && log_q.size() < e.size(); k++) @(posedge clk_i);
        if (log_q.size() < e.size()) begin
            mismatches++;
            $display("[FAIL] %s exp %0d got %0d", nm, e.size(), log_q.size());
            summarize();
        end else begin
            repeat (36) @(posedge clk_i);
            `CHK(nm, e.size(), log_q.size())
            foreach (e[j]) `CHK(nm, e[j], log_q[j])
            `CHK("idle busy", 8'h00, busy_o)
            log_q.delete();
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        need(8'h01, 8'h01);
        expect_log("data before command", '{4'h8, 4'h0});
        need(8'h00, 8'hC1);
        expect_log("chain order", '{4'hF, 4'hE, 4'h8});
        #1;
        keep_priority_i = 8'h08;
        need(8'h08, 8'h00);
        expect_log("kept priority", '{4'h3, 4'h3});
        summarize();
    end
endmodule // scpc_chain_test
